// file: rtl/acr_pkg.sv
// package of constants and types for the adc clock and soft-reset control
package acr_pkg;
	// register indices; the byte address is four times the index
	localparam logic [7:0] ACR_IDX_CLOCK_CONFIG  = 8'h08;
	localparam logic [7:0] ACR_IDX_RESET_CONTROL = 8'h09;
	localparam int         ACR_ADDR_W            = 8;
	localparam logic [7:0] ACR_ADDR_CLOCK_CONFIG  = 8'h20;
	localparam logic [7:0] ACR_ADDR_RESET_CONTROL = 8'h24;
	// reset values
	localparam logic [7:0] ACR_CLOCK_CONFIG_RST  = 8'h20;
	localparam logic [7:0] ACR_RESET_CONTROL_RST = 8'hc0;
	// writable bit masks, reserved bits stay zero
	localparam logic [7:0] ACR_CLOCK_CONFIG_MASK  = 8'hfe;
	localparam logic [7:0] ACR_RESET_CONTROL_MASK = 8'hc0;
	// field positions
	localparam int ACR_SRC_LSB      = 6;
	localparam int ACR_OSR_DIV_LSB  = 4;
	localparam int ACR_PIN_DIV_LSB  = 2;
	localparam int ACR_LS_HALF_BIT  = 1;
	localparam int ACR_FULL_RST_BIT = 7;
	localparam int ACR_MEAS_RST_BIT = 6;
	// cycles that the measurement-path reset pulse lasts
	localparam logic [3:0] ACR_MEAS_RST_CYCLES = 4'h8;

	// oversampling clock source encodings
	typedef enum logic [1:0]
	{
		ACR_SRC_HS_QUIET = 2'b00,
		ACR_SRC_HS_PIN   = 2'b01,
		ACR_SRC_EXT      = 2'b10,
		ACR_SRC_RSVD     = 2'b11
	} acr_src_t;

	// register bus request carrier
	typedef struct packed
	{
		logic [ACR_ADDR_W-1:0] addr;
		logic [7:0]            wdata;
		logic                  wr;
		logic                  rd;
	} acr_req_t;

	// measurement reset sequencer states
	typedef enum logic [0:0]
	{
		ACR_MR_IDLE = 1'b0,
		ACR_MR_BUSY = 1'b1
	} acr_mr_state_t;
endpackage

// file: rtl/acr_ctrl.sv
// clock selection, clock dividers and soft-reset control
//
// Function
// - bits 7:6 select oversampling clock source
// - bits 5:4 divide oversampling clock by 1..8
// - bits 3:2 divide oscillator before clock pin
// - writing 0 to bit 7 resets device
// - writing 0 to bit 6 resets measurement path
`timescale 1ns/100ps
module acr_ctrl
	import acr_pkg::*;
(
	input  wire logic                  SYS_CLK,        // 40 MHz system clock
	input  wire logic                  SYS_RST,        // async reset, active high
	input  wire logic [ACR_ADDR_W-1:0] REG_ADDR,       // register byte address
	input  wire logic [31:0]           REG_WDATA,      // write data
	input  wire logic                  REG_WR,         // write strobe
	input  wire logic                  REG_RD,         // read strobe
	output logic      [31:0]           REG_RDATA,      // read data, cycle after strobe
	input  wire logic                  HS_OSC_TICK,    // oscillator rate enable
	input  wire logic                  EXT_CLK_PIN,    // external clock pin, async
	input  wire logic                  LS_TICK,        // low-speed rate enable
	output logic                       OSR_TICK,       // oversampling clock enable
	output logic                       CLK_PIN_OUT,    // clock pin output level
	output logic                       CLK_PIN_OE,     // clock pin drive enable
	output logic                       LOW_SPEED_TICK, // low_speed_clock enable
	output logic                       SOFT_RST_ALL,   // whole-device soft reset
	output logic                       SOFT_RST_MEAS   // measurement path reset
);

	acr_req_t      req;                 // bundled bus request
	logic [7:0]    clock_config;        // clock configuration register
	logic [7:0]    reset_control;       // reset control register
	logic [7:0]    next_rdata;          // read mux value
	acr_src_t      src;                 // decoded clock source
	logic [1:0]    ext_sync;            // external clock synchroniser
	logic          ext_prev;            // last synchronised external level
	logic          ext_rise;            // external clock rising edge
	logic          src_tick;            // selected source tick
	logic [2:0]    osr_cnt;             // oversampling divider counter
	logic [2:0]    pin_cnt;             // clock pin divider counter
	logic          ls_phase;            // low-speed halving phase
	logic          full_req;            // full soft reset requested
	logic [3:0]    meas_cnt;            // measurement reset timer
	acr_mr_state_t mr_state;            // measurement reset state

	assign req = '{addr: REG_ADDR, wdata: REG_WDATA[7:0], wr: REG_WR, rd: REG_RD};
	assign src = acr_src_t'(clock_config[ACR_SRC_LSB +: 2]);

	// divider terminal test: ratio 2^code, counter wraps at ratio-1
	function automatic logic div_hit(input logic [2:0] cnt, input logic [1:0] code);
		logic [2:0] lim;
		lim = 3'((4'h1 << code) - 4'h1);
		div_hit = (cnt >= lim);
	endfunction

	// register writes; the full reset clears config back to defaults
	always_ff @(posedge SYS_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			clock_config <= ACR_CLOCK_CONFIG_RST;
		end
		else if (full_req)
		begin
			clock_config <= ACR_CLOCK_CONFIG_RST;
		end
		else if (req.wr && req.addr == ACR_ADDR_CLOCK_CONFIG)
		begin
			clock_config <= req.wdata & ACR_CLOCK_CONFIG_MASK;
		end
	end

	// reset control bits; a zero write starts a reset, hardware restores one
	always_ff @(posedge SYS_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			reset_control <= ACR_RESET_CONTROL_RST;
		end
		else if (full_req)
		begin
			reset_control <= ACR_RESET_CONTROL_RST;
		end
		else
		begin
			if (req.wr && req.addr == ACR_ADDR_RESET_CONTROL)
			begin
				reset_control <= req.wdata & ACR_RESET_CONTROL_MASK;
			end
			if (mr_state == ACR_MR_BUSY && meas_cnt == 4'h1)
			begin
				reset_control[ACR_MEAS_RST_BIT] <= 1'b1;
			end
		end
	end

	// full reset request: one-cycle pulse after the zero is stored
	// detect zero written
	assign full_req = ~reset_control[ACR_FULL_RST_BIT];

	always_ff @(posedge SYS_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			SOFT_RST_ALL <= 1'b0;
		end
		else
		begin
			SOFT_RST_ALL <= full_req;
		end
	end

	// measurement reset sequencer; held for a fixed number of cycles
	always_ff @(posedge SYS_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			mr_state <= ACR_MR_IDLE;
			meas_cnt <= 4'h0;
		end
		else if (full_req)
		begin
			mr_state <= ACR_MR_IDLE;
			meas_cnt <= 4'h0;
		end
		else
		begin
			case (mr_state)
				ACR_MR_IDLE:
				begin
					if (!reset_control[ACR_MEAS_RST_BIT])
					begin
						mr_state <= ACR_MR_BUSY;
						meas_cnt <= ACR_MEAS_RST_CYCLES;
					end
				end
				ACR_MR_BUSY:
				begin
					meas_cnt <= meas_cnt - 4'h1;
					if (meas_cnt == 4'h1)
					begin
						mr_state <= ACR_MR_IDLE;
					end
				end
				default:
				begin
					mr_state <= ACR_MR_IDLE;
				end
			endcase
		end
	end

	assign SOFT_RST_MEAS = (mr_state == ACR_MR_BUSY);

	// read data, one cycle after the strobe, zero otherwise
	always_comb
	begin
		next_rdata = 8'h00;
		if (req.addr == ACR_ADDR_CLOCK_CONFIG)
		begin
			next_rdata = clock_config;
		end
		else if (req.addr == ACR_ADDR_RESET_CONTROL)
		begin
			next_rdata = reset_control;
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			REG_RDATA <= 32'h0000_0000;
		end
		else if (req.rd)
		begin
			REG_RDATA <= {24'h00_0000, next_rdata};
		end
		else
		begin
			REG_RDATA <= 32'h0000_0000;
		end
	end

	// external clock pin synchroniser; only stage two is examined
	always_ff @(posedge SYS_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			ext_sync <= 2'b00;
			ext_prev <= 1'b0;
		end
		else
		begin
			ext_sync <= {ext_sync[0], EXT_CLK_PIN};
			ext_prev <= ext_sync[1];
		end
	end

	assign ext_rise = ext_sync[1] & ~ext_prev;

	// source select; reserved code picks nothing
	always_comb
	begin
		case (src)
			ACR_SRC_HS_QUIET: src_tick = HS_OSC_TICK;
			ACR_SRC_HS_PIN:   src_tick = HS_OSC_TICK;
			ACR_SRC_EXT:      src_tick = ext_rise;
			default:          src_tick = 1'b0;
		endcase
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			osr_cnt  <= 3'h0;
			OSR_TICK <= 1'b0;
		end
		else
		begin
			OSR_TICK <= 1'b0;
			if (src_tick)
			begin
				if (div_hit(osr_cnt, clock_config[ACR_OSR_DIV_LSB +: 2]))
				begin
					osr_cnt  <= 3'h0;
					OSR_TICK <= 1'b1;
				end
				else
				begin
					osr_cnt <= osr_cnt + 3'h1;
				end
			end
		end
	end

	// clock pin divider, output toggles so pin sees half the divided tick rate
	always_ff @(posedge SYS_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			pin_cnt     <= 3'h0;
			CLK_PIN_OUT <= 1'b0;
			CLK_PIN_OE  <= 1'b0;
		end
		else
		begin
			// drive pin only in mode 01
			CLK_PIN_OE <= (src == ACR_SRC_HS_PIN);
			if (src != ACR_SRC_HS_PIN)
			begin
				pin_cnt     <= 3'h0;
				CLK_PIN_OUT <= 1'b0;
			end
			else if (HS_OSC_TICK)
			begin
				if (div_hit(pin_cnt, clock_config[ACR_PIN_DIV_LSB +: 2]))
				begin
					pin_cnt     <= 3'h0;
					CLK_PIN_OUT <= ~CLK_PIN_OUT;
				end
				else
				begin
					pin_cnt <= pin_cnt + 3'h1;
				end
			end
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			ls_phase       <= 1'b0;
			LOW_SPEED_TICK <= 1'b0;
		end
		else
		begin
			LOW_SPEED_TICK <= 1'b0;
			if (LS_TICK)
			begin
				ls_phase       <= ~ls_phase;
				LOW_SPEED_TICK <= ~clock_config[ACR_LS_HALF_BIT] | ls_phase;
			end
		end
	end

endmodule // acr_ctrl

// file: tb/acr_ctrl_sva.sv
// concurrent checks on the ports of the clock and soft-reset control
`timescale 1ns/100ps
module acr_ctrl_sva
	import acr_pkg::*;
(
	input wire logic        SYS_CLK,
	input wire logic        SYS_RST,
	input wire logic [7:0]  REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [31:0] REG_RDATA,
	input wire logic        HS_OSC_TICK,
	input wire logic        LS_TICK,
	input wire logic        CLK_PIN_OUT,
	input wire logic        CLK_PIN_OE,
	input wire logic        LOW_SPEED_TICK,
	input wire logic        SOFT_RST_ALL,
	input wire logic        SOFT_RST_MEAS
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);

	a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
		else $error("read data not zero outside a read");
	// reset control also keeps its low six bits at zero
	a_rsvd_read_zero: assert property ($past(REG_RD) |-> REG_RDATA[31:8] == 24'h0 && !REG_RDATA[0]
		&& ($past(REG_ADDR) != ACR_ADDR_RESET_CONTROL || REG_RDATA[5:0] == 6'h0))
		else $error("reserved read bits not zero");
	a_meas_rst_len: assert property ($rose(SOFT_RST_MEAS) |-> SOFT_RST_MEAS [*8] ##1 !SOFT_RST_MEAS)
		else $error("measurement reset length wrong");
	a_meas_rst_cause: assert property ($rose(SOFT_RST_MEAS) |-> $past(REG_WR, 2)
		&& $past(REG_ADDR, 2) == ACR_ADDR_RESET_CONTROL && !$past(REG_WDATA[6], 2))
		else $error("measurement reset without its write");
	a_full_rst_pulse: assert property (SOFT_RST_ALL |-> ($past(REG_WR, 2) && !$past(REG_WDATA[7], 2)
		&& $past(REG_ADDR, 2) == ACR_ADDR_RESET_CONTROL) ##1 !SOFT_RST_ALL)
		else $error("device soft reset pulse wrong");
	a_ls_tick_cause: assert property (LOW_SPEED_TICK |-> $past(LS_TICK))
		else $error("low speed tick without input tick");
	a_pin_toggle_cause: assert property ($changed(CLK_PIN_OUT) && CLK_PIN_OE && $past(CLK_PIN_OE)
		|-> $past(HS_OSC_TICK))
		else $error("clock pin moved without oscillator tick");

	// main scenarios reached
	c_meas: cover property ($rose(SOFT_RST_MEAS));
	c_full: cover property (SOFT_RST_ALL);
	c_pin: cover property (CLK_PIN_OE && $changed(CLK_PIN_OUT));
endmodule // acr_ctrl_sva

bind acr_ctrl acr_ctrl_sva u_acr_ctrl_sva
(
	.SYS_CLK        (SYS_CLK),
	.SYS_RST        (SYS_RST),
	.REG_ADDR       (REG_ADDR),
	.REG_WDATA      (REG_WDATA),
	.REG_WR         (REG_WR),
	.REG_RD         (REG_RD),
	.REG_RDATA      (REG_RDATA),
	.HS_OSC_TICK    (HS_OSC_TICK),
	.LS_TICK        (LS_TICK),
	.CLK_PIN_OUT    (CLK_PIN_OUT),
	.CLK_PIN_OE     (CLK_PIN_OE),
	.LOW_SPEED_TICK (LOW_SPEED_TICK),
	.SOFT_RST_ALL   (SOFT_RST_ALL),
	.SOFT_RST_MEAS  (SOFT_RST_MEAS)
);

// file: tb/tb_acr_ctrl.sv
// self-checking testbench for the clock and soft-reset control
`timescale 1ns/100ps
module tb_acr_ctrl
	import acr_pkg::*;
;
	logic        SYS_CLK = 1'b0;
	logic        SYS_RST = 1'b1;
	logic [7:0]  REG_ADDR = 8'h00;
	logic [31:0] REG_WDATA = 32'h0;
	logic        REG_WR = 1'b0;
	logic        REG_RD = 1'b0;
	logic        HS_OSC_TICK = 1'b0;
	logic        EXT_CLK_PIN = 1'b0;
	logic        LS_TICK = 1'b0;
	logic [31:0] REG_RDATA;
	logic        OSR_TICK, CLK_PIN_OUT, CLK_PIN_OE, LOW_SPEED_TICK, SOFT_RST_ALL, SOFT_RST_MEAS;
	logic        last_pin = 1'b0;
	int          miscompares = 0, cmp_count = 0, n_osr, n_pin, n_ls, n_meas, n_all;

	always #12.5 SYS_CLK = ~SYS_CLK;

	acr_ctrl u_acr_ctrl
	(
		.SYS_CLK        (SYS_CLK),
		.SYS_RST        (SYS_RST),
		.REG_ADDR       (REG_ADDR),
		.REG_WDATA      (REG_WDATA),
		.REG_WR         (REG_WR),
		.REG_RD         (REG_RD),
		.REG_RDATA      (REG_RDATA),
		.HS_OSC_TICK    (HS_OSC_TICK),
		.EXT_CLK_PIN    (EXT_CLK_PIN),
		.LS_TICK        (LS_TICK),
		.OSR_TICK       (OSR_TICK),
		.CLK_PIN_OUT    (CLK_PIN_OUT),
		.CLK_PIN_OE     (CLK_PIN_OE),
		.LOW_SPEED_TICK (LOW_SPEED_TICK),
		.SOFT_RST_ALL   (SOFT_RST_ALL),
		.SOFT_RST_MEAS  (SOFT_RST_MEAS)
	);

	// output event counters, sampled on the quiet edge to avoid races
	always @(negedge SYS_CLK)
	begin
		n_osr += OSR_TICK;
		n_pin += (CLK_PIN_OUT !== last_pin);
		last_pin = CLK_PIN_OUT;
		n_ls += LOW_SPEED_TICK;
		n_meas += SOFT_RST_MEAS;
		n_all += SOFT_RST_ALL;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// read data compare over all 32 bits, so the zero upper bytes are checked too
	task automatic chk_rdata(input logic [7:0] a, input logic [7:0] e);
		cmp_count++;
		if (REG_RDATA !== {24'h00_0000, e})
		begin
			miscompares++;
			$display("wrong value at %0t: read of %h got %h expected %h", $time, a, REG_RDATA, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge SYS_CLK);
		REG_ADDR <= a;
		REG_WDATA <= {24'h0, d};
		REG_WR <= 1'b1;
		@(posedge SYS_CLK);
		REG_WR <= 1'b0;
	endtask

	// read data is looked at only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge SYS_CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge SYS_CLK);
		REG_RD <= 1'b0;
		@(negedge SYS_CLK);
		chk_rdata(a, e);
	endtask

	// n oscillator, low-speed and external ticks, one every second cycle
	task automatic run(input int n, input logic ext);
		n_osr = 0;
		n_pin = 0;
		n_ls = 0;
		repeat (n)
		begin
			@(posedge SYS_CLK);
			HS_OSC_TICK <= 1'b1;
			LS_TICK <= 1'b1;
			EXT_CLK_PIN <= ext;
			@(posedge SYS_CLK);
			HS_OSC_TICK <= 1'b0;
			LS_TICK <= 1'b0;
			EXT_CLK_PIN <= 1'b0;
		end
		repeat (8) @(posedge SYS_CLK);
	endtask

	task automatic t_regs();
		rd(ACR_ADDR_CLOCK_CONFIG, 8'h20);
		rd(ACR_ADDR_RESET_CONTROL, 8'hc0);
		wr(ACR_ADDR_CLOCK_CONFIG, 8'hff);
		rd(ACR_ADDR_CLOCK_CONFIG, 8'hfe);
		wr(ACR_ADDR_RESET_CONTROL, 8'hff);
		rd(ACR_ADDR_RESET_CONTROL, 8'hc0);
		wr(8'h28, 8'hff);
		rd(8'h28, 8'h00);
		$display("test regs done");
	endtask

	// oversampling, pin and low-speed ratios for every divider code
	task automatic t_div();
		for (int d = 0; d < 4; d++)
		begin
			wr(ACR_ADDR_CLOCK_CONFIG, {2'b01, 2'(d), 2'(d), 1'(d), 1'b0});
			run(32, 1'b0);
			chk(32'(n_osr), 32'(32 >> d), "osr ticks");
			chk(32'(n_pin), 32'(32 >> d), "pin toggles");
			chk(32'(n_ls), 32'((d % 2) ? 16 : 32), "ls ticks");
			chk({31'h0, CLK_PIN_OE}, 32'h1, "pin enable");
		end
		$display("test dividers done");
	endtask

	task automatic t_src();
		wr(ACR_ADDR_CLOCK_CONFIG, 8'h00);
		run(16, 1'b0);
		chk(32'(n_osr), 32'h10, "osr quiet source");
		chk({31'h0, CLK_PIN_OE}, 32'h0, "pin enable quiet");
		wr(ACR_ADDR_CLOCK_CONFIG, 8'hc0);
		run(16, 1'b0);
		chk(32'(n_osr), 32'h0, "osr reserved source");
		wr(ACR_ADDR_CLOCK_CONFIG, 8'h90);
		run(16, 1'b1);
		chk(32'(n_osr), 32'h8, "osr external source");
		$display("test sources done");
	endtask

	task automatic t_rst();
		n_meas = 0;
		wr(ACR_ADDR_RESET_CONTROL, 8'h80);
		rd(ACR_ADDR_RESET_CONTROL, 8'h80);
		repeat (12) @(posedge SYS_CLK);
		chk(32'(n_meas), 32'h8, "meas reset length");
		rd(ACR_ADDR_RESET_CONTROL, 8'hc0);
		n_all = 0;
		wr(ACR_ADDR_RESET_CONTROL, 8'h40);
		repeat (4) @(posedge SYS_CLK);
		chk(32'(n_all), 32'h1, "device reset pulse");
		rd(ACR_ADDR_CLOCK_CONFIG, 8'h20);
		rd(ACR_ADDR_RESET_CONTROL, 8'hc0);
		$display("test resets done");
	endtask

	// hardware reset after a run must bring a busy configuration back to defaults
	task automatic t_hw_rst();
		wr(ACR_ADDR_CLOCK_CONFIG, 8'h5e);
		run(4, 1'b0);
		chk(32'(n_osr), 32'h2, "osr before reset");
		chk({31'h0, CLK_PIN_OE}, 32'h1, "pin enable before reset");
		@(posedge SYS_CLK);
		SYS_RST <= 1'b1;
		repeat (2) @(posedge SYS_CLK);
		SYS_RST <= 1'b0;
		rd(ACR_ADDR_CLOCK_CONFIG, 8'h20);
		rd(ACR_ADDR_RESET_CONTROL, 8'hc0);
		chk({31'h0, CLK_PIN_OE}, 32'h0, "pin enable after reset");
		$display("test hardware reset done");
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		repeat (8) @(posedge SYS_CLK);
		SYS_RST <= 1'b0;
		t_regs();
		t_div();
		t_src();
		t_rst();
		t_hw_rst();
		complete_run();
	end

	// the tests need well under a thousand cycles
	initial
	begin
		#50000;
		miscompares++;
		complete_run();
	end
endmodule // tb_acr_ctrl
